// ### inc/fault_seq_pkg.sv
package fault_seq_pkg;

  // Clock rate and timing figures
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned FAST_TIME_MS = 2;
  localparam int unsigned SLOW_TIME_MS = 50;
  localparam int unsigned FAULT_WAIT_MS = 1000;
  localparam int unsigned LIGHT_TIME_MS = 200;
  localparam int unsigned WAKEUP_TIME_US = 150;
  localparam int unsigned BOOT_TIME_US = 100;
  localparam int unsigned FAST_CYCLES = FAST_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned SLOW_CYCLES = SLOW_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned FAULT_WAIT_CYCLES =
    FAULT_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned LIGHT_CYCLES = LIGHT_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKEUP_CYCLES =
    WAKEUP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BOOT_CYCLES = BOOT_TIME_US * (CLK_HZ / 1_000_000);

  localparam int TIMER_W = 24;

  // Peak current qualification
  localparam logic [3:0] PEAK_IGNORE_CYCLES = 4'hF;
  localparam logic [2:0] PEAK_TRIP_COUNT = 3'h4;

  // Register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] FAULT_CAUSE_OFFSET = 4'h8;

  // CONTROL fields
  localparam int CTRL_RESTART_EN_BIT = 0;
  localparam int CTRL_BURST_LSB = 8;
  localparam int CTRL_BURST_MSB = 11;
  localparam logic CTRL_RESTART_EN_RESET = 1'b1;
  localparam logic [3:0] CTRL_BURST_RESET = 4'h4;

  // STATUS fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_STATE_MSB = 2;
  localparam int STAT_SS_DONE_BIT = 3;
  localparam int STAT_BURST_OFF_BIT = 4;
  localparam int STAT_HIGH_GATE_BIT = 5;
  localparam int STAT_LS_BIT = 6;

  // FAULT_CAUSE fields, write one to clear
  localparam int FAULT_CAUSE_W = 8;
  localparam int FC_PEAK_BIT = 0;
  localparam int FC_FAST_BIT = 1;
  localparam int FC_SLOW_BIT = 2;
  localparam int FC_OVP_BIT = 3;
  localparam int FC_OTP_BIT = 4;
  localparam int FC_BULK_BIT = 5;
  localparam int FC_LIGHT_BIT = 6;
  localparam int FC_GATE_SUPPLY_BIT = 7;

  typedef enum logic [2:0] {
    ST_STARTUP = 3'h0,
    ST_SOURCE_ON = 3'h1,
    ST_SOURCE_OFF = 3'h2,
    ST_WAKEUP = 3'h3,
    ST_CHARGE_BOOT = 3'h4,
    ST_RUN = 3'h5,
    ST_LIGHT_LOAD = 3'h6,
    ST_FAULT = 3'h7
  } state_e;

  // Comparator and flag inputs, all asynchronous to clk
  typedef struct packed {
    logic peak_current_cmp;
    logic avg_current_fast_cmp;
    logic avg_current_slow_cmp;
    logic output_overvoltage_fault;
    logic over_temp;
    logic bootstrap_rail_uvlo;
    logic regulated_gate_supply_uvlo;
    logic supply_start_level;
    logic supply_restart_low;
    logic bulk_start;
    logic bulk_stop;
    logic bulk_overvoltage;
    logic feedback_copy_below_pin;
    logic demand_below_burst_level;
    logic capacitive_region_flag;
    logic resonant_cap_at_common_mode;
  } sense_s;

  typedef struct packed {
    logic high_side_gate_out;
    logic low_side_gate_out;
    logic startup_source_on;
    logic regulated_gate_supply_en;
    logic wavegen_en;
    logic softstart_en;
    logic analog_supply_level_sel;
    logic burst_level_sel;
    logic softstart_burst_pin_pulldown;
  } drive_s;

endpackage : fault_seq_pkg

// ### src/resonant_converter_fault_sequencer.sv
`timescale 1ns/1ps
// How it works
// R01: Count peak trips, stop stage past limit
// R02: Fast average current high 2 ms: shut down
// R03: Slow average current high 50 ms: shut down
// R04: Bootstrap undervoltage holds high-side gate off
// R05: Gate supply undervoltage forces both gates off
// R06: Over-temperature while switching stops all switching
// R07: Over-temperature during start-up turns source off
// R08: Effort is larger of demand and burst level
// R09: Demand below burst level: N cycles, stop
// R10: Demand above burst level: switch continuously
// R11: Before soft start done, skip burst compare
// R12: Last burst pulse ends at common-mode crossing
// R13: Supply above start level: source off, supply on
// R14: Low-side gate high for boot charge interval
// R15: Soft start begins right after boot charge
// R16: Soft start done when feedback copy below pin
// R17: After soft start, select analog supply, burst threshold
// R18: Capacitive region flag enables pin pull-down
// R19: Any fault stops, pauses, then restarts automatically
// R20: Peak fault after four consecutive tripped cycles
// R21: Ignore peak comparator first 15 start-up cycles
// R22: Fault state waits 1 s, outputs disabled
// R23: Light load below threshold 200 ms: fault
// R24: Average current timers clear when comparator drops
module resonant_converter_fault_sequencer #(
  parameter int unsigned FAST_CYCLES = fault_seq_pkg::FAST_CYCLES,
  parameter int unsigned SLOW_CYCLES = fault_seq_pkg::SLOW_CYCLES,
  parameter int unsigned FAULT_WAIT_CYCLES = fault_seq_pkg::FAULT_WAIT_CYCLES,
  parameter int unsigned LIGHT_CYCLES = fault_seq_pkg::LIGHT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire fault_seq_pkg::sense_s sense_async,
  input wire logic cycle_strobe,
  input wire logic high_side_request,
  input wire logic ls_request,
  input wire logic [fault_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output fault_seq_pkg::drive_s drive_reg,
  output logic softstart_done_reg,
  output logic [31:0] reg_rdata_reg
);

  localparam int TW = fault_seq_pkg::TIMER_W;

  fault_seq_pkg::sense_s sense_meta_reg;
  fault_seq_pkg::sense_s sense_reg;
  fault_seq_pkg::state_e state_reg;
  fault_seq_pkg::state_e state_next;
  fault_seq_pkg::drive_s drive_next;

  logic [TW-1:0] state_timer_reg;
  logic [TW-1:0] fast_timer_reg;
  logic [TW-1:0] slow_timer_reg;
  logic [TW-1:0] light_timer_reg;
  logic [3:0] peak_ignore_reg;
  logic [2:0] peak_trip_reg;
  logic [3:0] burst_cnt_reg;
  logic burst_off_reg;
  logic restart_en_reg;
  logic [3:0] burst_cycles_reg;
  logic [fault_seq_pkg::FAULT_CAUSE_W-1:0] fault_cause_reg;
  logic [fault_seq_pkg::FAULT_CAUSE_W-1:0] fault_event;

  logic running;
  logic switching;
  logic peak_fault;
  logic fast_fault;
  logic slow_fault;
  logic light_fault;
  logic any_run_fault;
  logic below_burst;

  function automatic logic is_run_state(input fault_seq_pkg::state_e s);
    return (s == fault_seq_pkg::ST_RUN) || (s == fault_seq_pkg::ST_LIGHT_LOAD);
  endfunction : is_run_state

  function automatic logic addr_hit(
    input logic [fault_seq_pkg::ADDR_W-1:0] a,
    input logic [fault_seq_pkg::ADDR_W-1:0] offset
  );
    return a == offset;
  endfunction : addr_hit

  // Two-stage synchroniser; only sense_reg is read by logic
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sense_meta_reg <= '0;
      sense_reg <= '0;
    end else begin
      sense_meta_reg <= sense_async;
      sense_reg <= sense_meta_reg;
    end
  end

  assign running = is_run_state(state_reg);
  assign switching = running && !burst_off_reg;
  assign below_burst = sense_reg.demand_below_burst_level
    && softstart_done_reg; // R11

  assign peak_fault = peak_trip_reg == fault_seq_pkg::PEAK_TRIP_COUNT; // R01
  assign fast_fault = fast_timer_reg == TW'(FAST_CYCLES - 1); // R02
  assign slow_fault = slow_timer_reg == TW'(SLOW_CYCLES - 1); // R03
  assign light_fault = light_timer_reg == TW'(LIGHT_CYCLES - 1); // R23

  always_comb begin
    fault_event = '0;
    if (running) begin
      fault_event[fault_seq_pkg::FC_PEAK_BIT] = peak_fault;
      fault_event[fault_seq_pkg::FC_FAST_BIT] = fast_fault;
      fault_event[fault_seq_pkg::FC_SLOW_BIT] = slow_fault;
      fault_event[fault_seq_pkg::FC_OVP_BIT] =
        sense_reg.output_overvoltage_fault;
      fault_event[fault_seq_pkg::FC_BULK_BIT] =
        sense_reg.bulk_overvoltage || sense_reg.bulk_stop;
      fault_event[fault_seq_pkg::FC_LIGHT_BIT] =
        (state_reg == fault_seq_pkg::ST_LIGHT_LOAD) && light_fault;
      fault_event[fault_seq_pkg::FC_GATE_SUPPLY_BIT] =
        sense_reg.regulated_gate_supply_uvlo;
    end
    // Over-temperature counts everywhere except the fault pause
    fault_event[fault_seq_pkg::FC_OTP_BIT] = sense_reg.over_temp
      && (state_reg != fault_seq_pkg::ST_FAULT); // R06 R07
  end

  assign any_run_fault = |fault_event;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fault_seq_pkg::ST_STARTUP: begin
        state_next = fault_seq_pkg::ST_SOURCE_ON;
      end
      fault_seq_pkg::ST_SOURCE_ON: begin
        if (sense_reg.supply_start_level
            && !sense_reg.supply_restart_low) begin
          state_next = fault_seq_pkg::ST_SOURCE_OFF; // R13
        end
      end
      fault_seq_pkg::ST_SOURCE_OFF: begin
        if (sense_reg.bulk_start && !sense_reg.bulk_stop
            && !sense_reg.bulk_overvoltage
            && !sense_reg.regulated_gate_supply_uvlo) begin
          state_next = fault_seq_pkg::ST_WAKEUP;
        end
      end
      fault_seq_pkg::ST_WAKEUP: begin
        if (state_timer_reg == TW'(fault_seq_pkg::WAKEUP_CYCLES - 1)) begin
          state_next = fault_seq_pkg::ST_CHARGE_BOOT;
        end
      end
      fault_seq_pkg::ST_CHARGE_BOOT: begin
        if (state_timer_reg == TW'(fault_seq_pkg::BOOT_CYCLES - 1)) begin
          state_next = fault_seq_pkg::ST_RUN; // R15
        end
      end
      fault_seq_pkg::ST_RUN: begin
        if (below_burst) begin
          state_next = fault_seq_pkg::ST_LIGHT_LOAD;
        end
      end
      fault_seq_pkg::ST_LIGHT_LOAD: begin
        if (!below_burst) begin
          state_next = fault_seq_pkg::ST_RUN;
        end
      end
      fault_seq_pkg::ST_FAULT: begin
        if (restart_en_reg
            && state_timer_reg == TW'(FAULT_WAIT_CYCLES - 1)) begin
          state_next = fault_seq_pkg::ST_SOURCE_ON; // R19 R22
        end
      end
    endcase
    // Supply collapse sends any live state back to source-on
    if (state_reg != fault_seq_pkg::ST_STARTUP
        && state_reg != fault_seq_pkg::ST_SOURCE_ON
        && state_reg != fault_seq_pkg::ST_FAULT
        && sense_reg.supply_restart_low) begin
      state_next = fault_seq_pkg::ST_SOURCE_ON;
    end
    if (any_run_fault) begin
      state_next = fault_seq_pkg::ST_FAULT; // R19
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= fault_seq_pkg::ST_STARTUP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Shared dwell timer for wake-up, boot charge and fault pause
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_timer_reg <= '0;
    end else if (state_next != state_reg) begin
      state_timer_reg <= '0;
    end else if (state_timer_reg != '1) begin
      state_timer_reg <= state_timer_reg + 1'b1; // R22
    end
  end

  // Average current qualification; any drop restarts the count
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fast_timer_reg <= '0;
      slow_timer_reg <= '0;
    end else begin
      if (!running || !sense_reg.avg_current_fast_cmp) begin
        fast_timer_reg <= '0; // R24
      end else if (!fast_fault) begin
        fast_timer_reg <= fast_timer_reg + 1'b1; // R02
      end
      if (!running || !sense_reg.avg_current_slow_cmp) begin
        slow_timer_reg <= '0; // R24
      end else if (!slow_fault) begin
        slow_timer_reg <= slow_timer_reg + 1'b1; // R03
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      light_timer_reg <= '0;
    end else if (state_reg != fault_seq_pkg::ST_LIGHT_LOAD) begin
      light_timer_reg <= '0;
    end else if (!light_fault) begin
      light_timer_reg <= light_timer_reg + 1'b1; // R23
    end
  end

  // Peak trips sampled once per switching cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      peak_ignore_reg <= '0;
      peak_trip_reg <= '0;
    end else if (!running) begin
      peak_ignore_reg <= '0;
      peak_trip_reg <= '0;
    end else if (cycle_strobe) begin
      if (peak_ignore_reg != fault_seq_pkg::PEAK_IGNORE_CYCLES) begin
        peak_ignore_reg <= peak_ignore_reg + 1'b1; // R21
      end else if (!sense_reg.peak_current_cmp) begin
        peak_trip_reg <= '0; // R20
      end else if (!peak_fault) begin
        peak_trip_reg <= peak_trip_reg + 1'b1; // R20
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      softstart_done_reg <= 1'b0;
    end else if (!running) begin
      softstart_done_reg <= 1'b0;
    end else if (sense_reg.feedback_copy_below_pin) begin
      softstart_done_reg <= 1'b1; // R16
    end
  end

  // Burst: counted tail of pulses, last one closed at mid-rail
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      burst_cnt_reg <= fault_seq_pkg::CTRL_BURST_RESET;
      burst_off_reg <= 1'b0;
    end else if (!running || !below_burst) begin
      burst_cnt_reg <= burst_cycles_reg;
      burst_off_reg <= 1'b0; // R10 R11
    end else if (!burst_off_reg) begin
      if (cycle_strobe && burst_cnt_reg != 4'h0) begin
        burst_cnt_reg <= burst_cnt_reg - 1'b1; // R09
      end
      if (burst_cnt_reg == 4'h0
          && sense_reg.resonant_cap_at_common_mode) begin
        burst_off_reg <= 1'b1; // R09 R12
      end
    end
  end

  always_comb begin
    drive_next = '0;
    drive_next.startup_source_on =
      (state_reg == fault_seq_pkg::ST_STARTUP
       || state_reg == fault_seq_pkg::ST_SOURCE_ON)
      && !sense_reg.over_temp; // R07 R13
    drive_next.regulated_gate_supply_en =
      state_reg != fault_seq_pkg::ST_STARTUP
      && state_reg != fault_seq_pkg::ST_SOURCE_ON
      && state_reg != fault_seq_pkg::ST_FAULT; // R13 R22
    drive_next.wavegen_en = switching && !any_run_fault; // R06
    drive_next.softstart_en = running; // R15
    drive_next.analog_supply_level_sel = softstart_done_reg; // R17
    drive_next.burst_level_sel = below_burst; // R08 R17
    drive_next.softstart_burst_pin_pulldown =
      running && sense_reg.capacitive_region_flag; // R18
    drive_next.high_side_gate_out = drive_next.wavegen_en && high_side_request
      && !sense_reg.bootstrap_rail_uvlo // R04
      && !sense_reg.regulated_gate_supply_uvlo; // R05
    drive_next.low_side_gate_out =
      ((state_reg == fault_seq_pkg::ST_CHARGE_BOOT) // R14
       || (drive_next.wavegen_en && ls_request))
      && !sense_reg.regulated_gate_supply_uvlo; // R05
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      restart_en_reg <= fault_seq_pkg::CTRL_RESTART_EN_RESET;
      burst_cycles_reg <= fault_seq_pkg::CTRL_BURST_RESET;
    end else if (reg_write
                 && addr_hit(reg_addr, fault_seq_pkg::CONTROL_OFFSET)) begin
      restart_en_reg <= reg_wdata[fault_seq_pkg::CTRL_RESTART_EN_BIT];
      burst_cycles_reg <= reg_wdata[fault_seq_pkg::CTRL_BURST_MSB:
                                    fault_seq_pkg::CTRL_BURST_LSB];
    end
  end

  // Sticky causes; a new event beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_cause_reg <= '0;
    end else if (reg_write && addr_hit(reg_addr,
                 fault_seq_pkg::FAULT_CAUSE_OFFSET)) begin
      fault_cause_reg <= (fault_cause_reg
        & ~reg_wdata[fault_seq_pkg::FAULT_CAUSE_W-1:0]) | fault_event;
    end else begin
      fault_cause_reg <= fault_cause_reg | fault_event;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata_reg <= '0;
    end else if (!reg_read) begin
      reg_rdata_reg <= '0;
    end else if (addr_hit(reg_addr, fault_seq_pkg::CONTROL_OFFSET)) begin
      reg_rdata_reg <= '0;
      reg_rdata_reg[fault_seq_pkg::CTRL_RESTART_EN_BIT] <= restart_en_reg;
      reg_rdata_reg[fault_seq_pkg::CTRL_BURST_MSB:
                    fault_seq_pkg::CTRL_BURST_LSB] <= burst_cycles_reg;
    end else if (addr_hit(reg_addr, fault_seq_pkg::STATUS_OFFSET)) begin
      reg_rdata_reg <= '0;
      reg_rdata_reg[fault_seq_pkg::STAT_STATE_MSB:
                    fault_seq_pkg::STAT_STATE_LSB] <= state_reg;
      reg_rdata_reg[fault_seq_pkg::STAT_SS_DONE_BIT] <= softstart_done_reg;
      reg_rdata_reg[fault_seq_pkg::STAT_BURST_OFF_BIT] <= burst_off_reg;
      reg_rdata_reg[fault_seq_pkg::STAT_HIGH_GATE_BIT] <=
        drive_reg.high_side_gate_out;
      reg_rdata_reg[fault_seq_pkg::STAT_LS_BIT] <=
        drive_reg.low_side_gate_out;
    end else if (addr_hit(reg_addr, fault_seq_pkg::FAULT_CAUSE_OFFSET)) begin
      reg_rdata_reg <= {{(32 - fault_seq_pkg::FAULT_CAUSE_W){1'b0}},
                        fault_cause_reg};
    end else begin
      reg_rdata_reg <= '0;
    end
  end

endmodule : resonant_converter_fault_sequencer

// ### testbench/fault_seq_asserts.sv
`timescale 1ns/1ps
module fault_seq_asserts #(
  parameter int unsigned FAST_CYCLES = 20,
  parameter int unsigned SLOW_CYCLES = 50
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire fault_seq_pkg::sense_s sense_async,
  input wire fault_seq_pkg::drive_s drive_reg,
  input wire logic softstart_done_reg
);
  int unsigned boot_cnt;
  int unsigned fast_cnt;
  int unsigned slow_cnt;
  logic boot_hold;
  assign boot_hold = drive_reg.low_side_gate_out && !drive_reg.wavegen_en;
  // Run lengths, so long holds need no deep repetition
  always_ff @(posedge clk) begin
    boot_cnt <= (reset_n && boot_hold) ? boot_cnt + 1 : 0;
  end
  always_ff @(posedge clk) begin
    fast_cnt <= (reset_n && sense_async.avg_current_fast_cmp) ?
      fast_cnt + 1 : 0;
  end
  always_ff @(posedge clk) begin
    slow_cnt <= (reset_n && sense_async.avg_current_slow_cmp) ?
      slow_cnt + 1 : 0;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_gates_off;
    !drive_reg.high_side_gate_out && !drive_reg.low_side_gate_out;
  endsequence
  sequence s_charged;
    drive_reg.wavegen_en && boot_cnt >= fault_seq_pkg::BOOT_CYCLES - 1 &&
      boot_cnt <= fault_seq_pkg::BOOT_CYCLES + 1;
  endsequence
  property p_gate_uvlo;
    sense_async.regulated_gate_supply_uvlo [*6] |-> s_gates_off;
  endproperty
  property p_boot_uvlo;
    sense_async.bootstrap_rail_uvlo [*6] |-> !drive_reg.high_side_gate_out;
  endproperty
  property p_otp;
    sense_async.over_temp [*6] |-> !drive_reg.wavegen_en ##0 s_gates_off;
  endproperty
  property p_excl;
    !(drive_reg.startup_source_on && drive_reg.regulated_gate_supply_en);
  endproperty
  property p_boot;
    $rose(drive_reg.softstart_en) |-> s_charged;
  endproperty
  property p_sel;
    (drive_reg.analog_supply_level_sel || drive_reg.burst_level_sel) |->
      (softstart_done_reg || $past(softstart_done_reg));
  endproperty
  property p_fast;
    fast_cnt >= FAST_CYCLES + 6 |-> !drive_reg.wavegen_en;
  endproperty
  property p_slow;
    slow_cnt >= SLOW_CYCLES + 6 |-> !drive_reg.wavegen_en;
  endproperty
  property p_pulldown;
    (sense_async.capacitive_region_flag && drive_reg.wavegen_en) [*6] |->
      drive_reg.softstart_burst_pin_pulldown;
  endproperty
  a_gate_uvlo: assert property (p_gate_uvlo)
    else $error("gate on under gate supply undervoltage");
  a_boot_uvlo: assert property (p_boot_uvlo)
    else $error("high side on under bootstrap undervoltage");
  a_otp: assert property (p_otp)
    else $error("switching under over-temperature");
  a_excl: assert property (p_excl)
    else $error("start-up source and gate supply both on");
  a_boot: assert property (p_boot)
    else $error("soft start without full boot charge");
  a_sel: assert property (p_sel)
    else $error("burst or supply select before soft start done");
  a_fast: assert property (p_fast)
    else $error("switching after long fast average current");
  a_slow: assert property (p_slow)
    else $error("switching after long slow average current");
  a_pulldown: assert property (p_pulldown)
    else $error("no pin pull-down in capacitive region");
endmodule : fault_seq_asserts

bind resonant_converter_fault_sequencer fault_seq_asserts #(
  .FAST_CYCLES(FAST_CYCLES),
  .SLOW_CYCLES(SLOW_CYCLES)
) chk_u (.clk(clk), .reset_n(reset_n), .sense_async(sense_async),
  .drive_reg(drive_reg), .softstart_done_reg(softstart_done_reg));

// ### testbench/wavegen_model.sv
`timescale 1ns/1ps
// Waveform generator stand-in: still while disabled, 8-cycle period
module wavegen_model (
  input wire logic clk,
  input wire logic en,
  output logic cycle_strobe,
  output logic high_side_request,
  output logic ls_request
);
  logic [2:0] phase_reg;
  always_ff @(posedge clk) begin
    if (!en) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
    end
  end
  assign cycle_strobe = en && (phase_reg == 3'h7);
  // Halves never overlap, so no shoot-through request
  assign high_side_request = en && !phase_reg[2];
  assign ls_request = en && phase_reg[2];
endmodule : wavegen_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned FAST_P = 20;
  localparam int unsigned SLOW_P = 50;
  localparam int unsigned WAIT_P = 40;
  localparam int unsigned LIGHT_P = 200;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  fault_seq_pkg::sense_s sense = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [fault_seq_pkg::ADDR_W-1:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] rdata;
  logic strobe;
  logic high_req;
  logic ls_req;
  fault_seq_pkg::drive_s drive;
  logic ss_done;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  always #50 clk = ~clk;
  resonant_converter_fault_sequencer #(.FAST_CYCLES(FAST_P),
    .SLOW_CYCLES(SLOW_P), .FAULT_WAIT_CYCLES(WAIT_P),
    .LIGHT_CYCLES(LIGHT_P)) dut_u (.clk(clk), .reset_n(reset_n),
    .sense_async(sense), .cycle_strobe(strobe), .high_side_request(high_req),
    .ls_request(ls_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .drive_reg(drive),
    .softstart_done_reg(ss_done), .reg_rdata_reg(rdata));
  wavegen_model wg_u (.clk(clk), .en(drive.wavegen_en),
    .cycle_strobe(strobe), .high_side_request(high_req), .ls_request(ls_req));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask : chk1
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdc(input string what, input logic [3:0] a,
      input logic [31:0] mask, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(what, exp, rdata & mask);
    @(posedge clk);
  endtask : rdc
  task automatic run_up();
    wait (drive.softstart_en === 1'b1);
    @(posedge clk);
  endtask : run_up
  // Raise one sense bit, expect a stop with the matching cause
  task automatic trip(input int b, input int len, input logic [7:0] cb);
    sense[b] <= 1'b1;
    repeat (len) @(posedge clk);
    chk("fault outputs", 32'h0, {23'h0, drive});
    sense[b] <= 1'b0;
    rdc("cause", 4'h8, {24'h0, cb}, {24'h0, cb});
    wr(4'h8, 32'hFF);
  endtask : trip
  // Short highs must never add up to a trip
  task automatic avg_test(input int b, input int len, input logic [7:0] cb);
    repeat (3) begin
      sense[b] <= 1'b1;
      repeat (len - 6) @(posedge clk);
      sense[b] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    chk1("short highs", 1'b1, drive.wavegen_en);
    trip(b, len + 8, cb);
  endtask : avg_test
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc("control", 4'h0, 32'hFFFFFFFF, 32'h00000401);
    rdc("cause", 4'h8, 32'hFF, 32'h0);
    rdc("unmapped", 4'hC, 32'hFFFFFFFF, 32'h0);
    wr(4'h4, 32'h7);
    rdc("status", 4'h4, 32'h7, 32'h1);
    chk1("source on", 1'b1, drive.startup_source_on);
    sense.supply_start_level <= 1'b1;
    sense.bulk_start <= 1'b1;
    @(posedge clk iff drive.regulated_gate_supply_en);
    chk1("source off", 1'b0, drive.startup_source_on);
    @(posedge clk iff drive.low_side_gate_out);
    n = 0;
    while (drive.softstart_en !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk("boot cycles", fault_seq_pkg::BOOT_CYCLES, n);
    chk1("wavegen", 1'b1, drive.wavegen_en);
    sense.peak_current_cmp <= 1'b1;
    repeat (18) @(posedge clk iff strobe);
    repeat (3) @(posedge clk);
    chk1("three trips", 1'b1, drive.wavegen_en);
    @(posedge clk iff strobe);
    repeat (4) @(posedge clk);
    chk("peak stop", 32'h0, {23'h0, drive});
    sense.peak_current_cmp <= 1'b0;
    n = 0;
    while (drive.startup_source_on !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk1("fault pause", 1'b1, n >= WAIT_P - 8);
    rdc("cause", 4'h8, 32'hFF, 32'h01);
    wr(4'h8, 32'hFF);
    rdc("cause cleared", 4'h8, 32'hFF, 32'h0);
    $display("test start and peak done");
    run_up();
    sense.demand_below_burst_level <= 1'b1;
    repeat (8) @(posedge clk);
    chk1("no burst effort", 1'b0, drive.burst_level_sel);
    chk1("keeps running", 1'b1, drive.wavegen_en);
    sense.demand_below_burst_level <= 1'b0;
    sense.capacitive_region_flag <= 1'b1;
    repeat (8) @(posedge clk);
    chk1("pull-down", 1'b1, drive.softstart_burst_pin_pulldown);
    sense.capacitive_region_flag <= 1'b0;
    // Half of every 8-cycle period drives the high side
    n = 0;
    repeat (24) begin
      @(negedge clk);
      n += (drive.high_side_gate_out === 1'b1);
    end
    chk("high side before", 32'hC, n);
    @(posedge clk);
    sense.bootstrap_rail_uvlo <= 1'b1;
    repeat (6) @(posedge clk);
    n = 0;
    repeat (24) begin
      @(negedge clk);
      n += (drive.high_side_gate_out !== 1'b0);
    end
    chk("high side cycles", 32'h0, n);
    @(posedge clk);
    sense.bootstrap_rail_uvlo <= 1'b0;
    trip(9, 8, 8'h80);
    $display("test gates done");
    run_up();
    avg_test(14, FAST_P, 8'h02);
    $display("test fast average done");
    run_up();
    sense.feedback_copy_below_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk1("soft start done", 1'b1, ss_done);
    chk1("supply select", 1'b1, drive.analog_supply_level_sel);
    sense.demand_below_burst_level <= 1'b1;
    repeat (6) @(posedge clk);
    chk1("burst effort", 1'b1, drive.burst_level_sel);
    repeat (4) @(posedge clk iff strobe);
    repeat (12) @(posedge clk);
    chk1("waits for crossing", 1'b1, drive.wavegen_en);
    sense.resonant_cap_at_common_mode <= 1'b1;
    repeat (6) @(posedge clk);
    chk1("burst off", 1'b0, drive.wavegen_en);
    rdc("burst off flag", 4'h4, 32'h10, 32'h10);
    sense.demand_below_burst_level <= 1'b0;
    sense.resonant_cap_at_common_mode <= 1'b0;
    repeat (6) @(posedge clk);
    chk1("resumes", 1'b1, drive.wavegen_en);
    avg_test(13, SLOW_P, 8'h04);
    $display("test burst and slow average done");
    run_up();
    trip(2, LIGHT_P + 30, 8'h40);
    $display("test light load done");
    run_up();
    trip(12, 8, 8'h08);
    run_up();
    trip(11, 8, 8'h10);
    sense.supply_start_level <= 1'b0;
    wait (drive.startup_source_on === 1'b1);
    @(posedge clk);
    sense.over_temp <= 1'b1;
    repeat (6) @(posedge clk);
    chk1("source off on heat", 1'b0, drive.startup_source_on);
    // Restart disabled: the pause must not end
    sense.over_temp <= 1'b0;
    wr(4'h0, 32'h00000300);
    rdc("control", 4'h0, 32'hFFFFFFFF, 32'h00000300);
    repeat (60) @(posedge clk);
    rdc("held in fault", 4'h4, 32'h7, 32'h7);
    $display("test over-temperature done");
    finish_test();
  end
endmodule : tb_top
